// ===== rtl/vac_alarm_config.sv
`timescale 1ns/10ps
`include "vac_regs.svh"
module vac_alarm_config
  import vac_pkg::*;
#(
  parameter int DW = 16
) (
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          reset,
  // Register port from the serial interface, same clock.
  input  wire logic [6:0]    reg_addr,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [DW-1:0] reg_wdata,
  output logic      [DW-1:0] reg_rdata,
  // Measurement side, same clock.
  input  vac_mode_t          mode,
  input  wire logic          record_done,
  input  wire logic [1:0]    record_rate,
  input  vac_meas_t          meas,
  input  wire logic [DW-1:0] temp_value,
  input  wire logic [DW-1:0] supply_value,
  input  wire logic          clear_status,
  // Alarm pins.
  output logic               alarm_out_first,
  output logic               alarm_out_second
);
  typedef struct packed {
    logic [DW-1:0] sel;
    logic [DW-1:0] sys_thr;
    logic [DW-1:0] ctrl;
    logic [DW-1:0] status;
    logic [DW-1:0] rdata;
    logic [5:0]    hit_prev;
    logic [3:0]    delay_cnt;
    logic [2:0]    scan;
    logic          scanning;
    logic          pin1;
    logic          pin2;
  } vac_state_t;

  vac_state_t  s_q, s_d;
  logic [4:0]  mem_addr;
  logic        mem_we;
  vac_alarm_t  mem_wdata;
  vac_alarm_t  cur;
  logic [5:0]  hit;
  logic        sys_hit;
  logic [DW-1:0] sys_val;
  logic [DW-1:0] z_val;

  vac_alarm_mem #(.DEPTH(32)) u_mem (
    .clk   (clk),
    .reset (reset),
    .addr  (mem_addr),
    .we    (mem_we),
    .wdata (mem_wdata),
    .rdata (cur)
  );

  assign reg_rdata        = s_q.rdata;
  assign alarm_out_first  = s_q.pin1;
  assign alarm_out_second = s_q.pin2;

  // Memory address: during a record scan it walks the bands, else follows the selector.
  always_comb begin
    if (s_q.scanning) begin
      mem_addr = {record_rate, s_q.scan};
    end else begin
      mem_addr = {s_q.sel[9:8], s_q.sel[2:0]}; // RULE8
    end
  end

  // ------------------------------------------------------------
  // Host writes into the selected alarm
  // ------------------------------------------------------------
  always_comb begin
    mem_wdata = cur;
    mem_we    = 1'b0;
    if (reg_wr && !s_q.scanning) begin
      mem_we = 1'b1; // RULE10
      unique case (reg_addr)
        `VAC_OFS_BAND_LO: mem_wdata.lo   = reg_wdata[11:0]; // RULE19
        `VAC_OFS_BAND_HI: mem_wdata.hi   = reg_wdata[11:0]; // RULE19
        `VAC_OFS_L1_X:    mem_wdata.l1_x = reg_wdata;
        `VAC_OFS_L1_Y:    mem_wdata.l1_y = reg_wdata;
        `VAC_OFS_L1_Z:    mem_wdata.l1_z = reg_wdata;
        `VAC_OFS_L2_X:    mem_wdata.l2_x = reg_wdata;
        `VAC_OFS_L2_Y:    mem_wdata.l2_y = reg_wdata;
        `VAC_OFS_L2_Z:    mem_wdata.l2_z = reg_wdata;
        default:          mem_we = 1'b0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Threshold comparison
  // ------------------------------------------------------------
  // Level-2 is assumed at or above level-1, so no ordering check is made here. RULE7
  always_comb begin
    z_val = (mode == VAC_MODE_TIME && meas.rss_en) ? meas.root_sum_square : meas.mag_z; // RULE6
    hit[0] = s_q.ctrl[0] && meas.mag_x > cur.l1_x;
    hit[1] = s_q.ctrl[1] && meas.mag_y > cur.l1_y; // RULE1
    hit[2] = s_q.ctrl[2] && z_val > cur.l1_z; // RULE2
    hit[3] = s_q.ctrl[0] && meas.mag_x > cur.l2_x; // RULE3
    hit[4] = s_q.ctrl[1] && meas.mag_y > cur.l2_y; // RULE4
    hit[5] = s_q.ctrl[2] && z_val > cur.l2_z; // RULE5
    if (cur.hi < cur.lo && mode == VAC_MODE_SPEC) begin
      hit = '0;
    end
    sys_val = s_q.ctrl[`VAC_BIT_SYS_SRC] ? temp_value : supply_value; // RULE11
    if (s_q.ctrl[`VAC_BIT_SYS_POL]) begin
      sys_hit = sys_val < s_q.sys_thr; // RULE12
    end else begin
      sys_hit = sys_val > s_q.sys_thr; // RULE12
    end
    sys_hit = sys_hit && s_q.ctrl[3]; // RULE13
  end

  // ------------------------------------------------------------
  // State update
  // ------------------------------------------------------------
  always_comb begin
    logic [DW-1:0] flags;
    logic [DW-1:0] rd;
    logic [5:0]    hit_use;
    flags = '0;
    rd    = '0;
    s_d   = s_q;
    // In spectral mode the first scan cycle still shows the selector's slot, which may
    // belong to another rate, so its result is dropped.
    hit_use = (s_q.scan == 3'h1 && mode != VAC_MODE_TIME) ? 6'h00 : hit;

    // One band per cycle after a record; the memory read lags by a cycle, so compare on next.
    if (record_done && !s_q.scanning && mode != VAC_MODE_OFF) begin
      s_d.scanning = 1'b1;
      s_d.scan     = 3'h1;
      s_d.hit_prev = '0;
    end else if (s_q.scanning) begin
      s_d.hit_prev = s_q.hit_prev | hit_use; // RULE20
      if (s_q.scan == 3'h7 || mode == VAC_MODE_TIME) begin
        s_d.scanning = 1'b0;
        if ((s_q.hit_prev | hit_use) != '0) begin
          if (s_q.delay_cnt >= s_q.ctrl[11:8]) begin // RULE16
            flags[13:`VAC_ST_A2_LO] = s_q.hit_prev[5:3] | hit_use[5:3];
            flags[10:`VAC_ST_A1_LO] = s_q.hit_prev[2:0] | hit_use[2:0];
          end else begin
            s_d.delay_cnt = s_q.delay_cnt + 4'h1; // RULE20
          end
        end else begin
          s_d.delay_cnt = '0;
        end
      end else begin
        s_d.scan = s_q.scan + 3'h1;
      end
    end
    flags[`VAC_ST_SYS] = sys_hit;

    // Register reads; the view of band registers is that of the selected alarm. RULE9
    unique case (reg_addr)
      `VAC_OFS_BAND_LO: rd = {4'h0, cur.lo};
      `VAC_OFS_BAND_HI: rd = {4'h0, cur.hi};
      `VAC_OFS_L1_X:    rd = cur.l1_x;
      `VAC_OFS_L1_Y:    rd = cur.l1_y;
      `VAC_OFS_L1_Z:    rd = cur.l1_z;
      `VAC_OFS_L2_X:    rd = cur.l2_x;
      `VAC_OFS_L2_Y:    rd = cur.l2_y;
      `VAC_OFS_L2_Z:    rd = cur.l2_z;
      `VAC_OFS_SEL:     rd = s_q.sel;
      `VAC_OFS_SYS_THR: rd = s_q.sys_thr;
      `VAC_OFS_CTRL:    rd = s_q.ctrl;
      `VAC_OFS_STATUS:  rd = s_q.status; // RULE18
      default:          rd = '0;
    endcase
    if (reg_rd) begin
      s_d.rdata = rd;
    end

    // Status flags: latched, or with only the system flag live, with new events winning over any clear.
    if (s_q.ctrl[`VAC_BIT_LATCH]) begin
      s_d.status = s_q.status; // RULE15
      if (clear_status) begin
        s_d.status = '0; // RULE15
      end
    end else begin
      s_d.status[`VAC_ST_SYS] = 1'b0;
    end
    if (reg_rd && reg_addr == `VAC_OFS_STATUS && !s_q.ctrl[`VAC_BIT_NOCLR]) begin
      s_d.status[13:`VAC_ST_A1_LO] = '0; // RULE17
    end
    s_d.status = s_d.status | flags; // RULE18
    s_d.status[15] = 1'b0;
    s_d.status[7:0] = '0;

    if (reg_wr) begin
      unique case (reg_addr)
        `VAC_OFS_SEL:     s_d.sel     = reg_wdata & `VAC_SEL_MASK; // RULE8
        `VAC_OFS_SYS_THR: s_d.sys_thr = reg_wdata;
        `VAC_OFS_CTRL:    s_d.ctrl    = {3'h0, reg_wdata[12:0]};
        default:          s_d.sel     = s_q.sel;
      endcase
    end

    s_d.pin1 = s_q.ctrl[`VAC_BIT_PIN_EN] && (s_q.status[10:8] != '0 || s_q.status[`VAC_ST_SYS]); // RULE14
    s_d.pin2 = s_q.ctrl[`VAC_BIT_PIN_EN] && (s_q.status[13:11] != '0); // RULE14
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q      <= '0;
      s_q.ctrl <= `VAC_CTRL_RESET; // RULE15
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ===== rtl/vac_regs.svh
// Operation
// RULE1: Spectral modes use y level-1 threshold of the selected alarm to raise alarm 1.
// RULE2: Spectral modes use z level-1 threshold of the selected alarm to raise alarm 1.
// RULE3: Spectral modes use x level-2 threshold of the selected alarm to raise alarm 2.
// RULE4: Spectral modes use y level-2 threshold of the selected alarm to raise alarm 2.
// RULE5: Spectral modes use z level-2 threshold of the selected alarm to raise alarm 2.
// RULE6: Time-capture compares statistics; z compares root-sum-square when that is enabled.
// RULE7: Host programs each level-2 threshold at or above its level-1 threshold.
// RULE8: Selector bits 9:8 pick rate setting, bits 2:0 pick band one to six.
// RULE9: Selecting an alarm makes band and threshold reads return its stored settings.
// RULE10: Writes to band or threshold registers update the selected alarm's stored setting. The code drops such writes while a record scan runs.
// RULE11: Control bit 4 picks system source: one temperature, zero supply.
// RULE12: Control bit 5 set triggers below threshold; clear triggers above.
// RULE13: Control bits 0 to 3 enable x, y, z and system alarms.
// RULE14: Control bit 6 routes alarm 1 and alarm 2 to the two alarm pins.
// RULE15: Control bit 7, reset one, latches flags until the clear-status command.
// RULE16: Control bits 11:8 give records an alarm must persist before flag sets.
// RULE17: Status read clears spectral flags unless control bit 12 is set.
// RULE18: Status bit 14 system, 13 to 11 alarm 2 zyx, 10 and 9 alarm 1 zy.
// RULE19: Each band has 12-bit lower and upper bin numbers, 0 to 4095.
// RULE20: After each spectral record compare enabled axes, advance delay count, set flags.
`ifndef VAC_REGS_SVH
`define VAC_REGS_SVH
`define VAC_OFS_BAND_LO   7'h20
`define VAC_OFS_BAND_HI   7'h22
`define VAC_OFS_L1_X      7'h24
`define VAC_OFS_L1_Y      7'h26
`define VAC_OFS_L1_Z      7'h28
`define VAC_OFS_L2_X      7'h2a
`define VAC_OFS_L2_Y      7'h2c
`define VAC_OFS_L2_Z      7'h2e
`define VAC_OFS_SEL       7'h30
`define VAC_OFS_SYS_THR   7'h32
`define VAC_OFS_CTRL      7'h34
`define VAC_OFS_STATUS    7'h3c
`define VAC_CTRL_RESET    16'h0080
`define VAC_SEL_MASK      16'h0307
`define VAC_BIN_MASK      16'h0fff
`define VAC_BIT_SYS_SRC   4
`define VAC_BIT_SYS_POL   5
`define VAC_BIT_PIN_EN    6
`define VAC_BIT_LATCH     7
`define VAC_BIT_NOCLR     12
`define VAC_ST_SYS        14
`define VAC_ST_A2_LO      11
`define VAC_ST_A1_LO      8
`endif

// ===== rtl/vac_pkg.sv
package vac_pkg;
  typedef enum logic [2:0] {
    VAC_MODE_OFF = 3'h1,
    VAC_MODE_SPEC = 3'h2,
    VAC_MODE_TIME = 3'h4
  } vac_mode_t;

  typedef struct packed {
    logic [11:0] lo;
    logic [11:0] hi;
    logic [15:0] l1_x;
    logic [15:0] l1_y;
    logic [15:0] l1_z;
    logic [15:0] l2_x;
    logic [15:0] l2_y;
    logic [15:0] l2_z;
  } vac_alarm_t;

  typedef struct packed {
    logic [15:0] mag_x;
    logic [15:0] mag_y;
    logic [15:0] mag_z;
    logic [15:0] root_sum_square;
    logic        rss_en;
  } vac_meas_t;

  typedef struct packed {
    logic [4:0]  addr;
    logic        we;
    vac_alarm_t  wdata;
    vac_alarm_t  rdata;
  } vac_mem_state_t;
endpackage

// ===== rtl/vac_alarm_mem.sv
`timescale 1ns/10ps
module vac_alarm_mem
  import vac_pkg::*;
#(
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       reset,
  // Access port.
  input  wire logic [4:0] addr,
  input  wire logic       we,
  input  vac_alarm_t      wdata,
  output vac_alarm_t      rdata
);
  vac_alarm_t mem_q [DEPTH];
  vac_alarm_t rdata_q;

  assign rdata = rdata_q;

  // Stored alarms keep their contents through reset; only the read register clears.
  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[addr] <= wdata;
    end
    if (reset) begin
      rdata_q <= '0;
    end else if (we) begin
      rdata_q <= wdata;
    end else begin
      rdata_q <= mem_q[addr];
    end
  end
endmodule

// ===== verif/vac_alarm_config_props.sv
`timescale 1ns/10ps
module vac_alarm_config_props
  import vac_pkg::*;
(
  // Clock and reset.
  input wire logic        clk,
  input wire logic        reset,
  // Register port.
  input wire logic [6:0]  reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  // Measurement side.
  input vac_mode_t        mode,
  input wire logic        record_done,
  input wire logic [1:0]  record_rate,
  input vac_meas_t        meas,
  input wire logic [15:0] temp_value,
  input wire logic [15:0] supply_value,
  input wire logic        clear_status,
  // Alarm pins.
  input wire logic        alarm_out_first,
  input wire logic        alarm_out_second
);
  logic [15:0] ctrl_q, thr_q, sel_q, sys_v;
  logic [3:0]  quiet_q;
  logic        sys_hit;
  // Shadows follow host writes so reads can be judged without seeing the body.
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= 16'h0080;
      thr_q <= 16'h0000;
      sel_q <= 16'h0000;
      quiet_q <= 4'h0;
    end else begin
      if (reg_wr && reg_addr == 7'h34) ctrl_q <= {3'h0, reg_wdata[12:0]};
      if (reg_wr && reg_addr == 7'h32) thr_q <= reg_wdata;
      if (reg_wr && reg_addr == 7'h30) sel_q <= reg_wdata & 16'h0307;
      quiet_q <= record_done ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
    end
  end
  always_comb begin
    sys_v = ctrl_q[4] ? temp_value : supply_value;
    sys_hit = ctrl_q[5] ? (sys_v < thr_q) : (sys_v > thr_q);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_unmapped_zero: assert property (reg_rd && reg_addr == 7'h3e |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_ctrl_readback: assert property (reg_rd && reg_addr == 7'h34 |=> reg_rdata == $past(ctrl_q))
    else $error("control readback wrong");
  a_thr_readback: assert property (reg_rd && reg_addr == 7'h32 |=> reg_rdata == $past(thr_q))
    else $error("system threshold readback wrong");
  a_sel_readback: assert property (reg_rd && reg_addr == 7'h30 |=> reg_rdata == $past(sel_q))
    else $error("selector readback wrong");
  a_pin_gate: assert property (!ctrl_q[6] [*3] |-> !alarm_out_first && !alarm_out_second)
    else $error("pin driven while routing off");
  a_sys_raise: assert property ((ctrl_q[6] && ctrl_q[3] && sys_hit) [*3] |-> ##[0:2] alarm_out_first)
    else $error("system alarm missing on pin");
  a_stat_clear: assert property ((reg_rd && reg_addr == 7'h3c && !ctrl_q[12] && quiet_q > 4'ha) ##[1:4]
    (reg_rd && reg_addr == 7'h3c) |=> reg_rdata[13:8] == 6'h00) else $error("status not cleared by read");
  c_spec: cover property (record_done ##[8:10] alarm_out_second);
  c_sys: cover property ($rose(alarm_out_first) && mode == VAC_MODE_OFF);
  c_stat: cover property (reg_rd && reg_addr == 7'h3c ##1 reg_rdata != 16'h0000);
endmodule

// ===== verif/vac_host.sv
`timescale 1ns/10ps
module vac_host (
  // Clock.
  input wire logic        clk,
  // Register port.
  output logic     [6:0]  reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic     [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  // Every access leaves an idle cycle behind it, which also covers the
  // settle time of the selector before a threshold read.
  initial begin
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_wdata = ~v;
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    @(posedge clk);
    #1;
    v = reg_rdata;
  endtask
endmodule

// ===== verif/vibration_alarm_config_bench.sv
`timescale 1ns/10ps
module vibration_alarm_config_bench;
  import vac_pkg::*;
  logic        clk, reset, wr, rd, rec, clr, p1, p2;
  logic [6:0]  addr;
  logic [15:0] wdat, rdat, temp, supp, d;
  logic [1:0]  rate;
  vac_mode_t   mode;
  vac_meas_t   meas;
  int          errors, tests_run, cyc;
  vac_alarm_config dut_u (.clk(clk), .reset(reset), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
    .reg_wdata(wdat), .reg_rdata(rdat), .mode(mode), .record_done(rec), .record_rate(rate), .meas(meas),
    .temp_value(temp), .supply_value(supp), .clear_status(clr), .alarm_out_first(p1), .alarm_out_second(p2));
  vac_host host_u (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdat), .reg_rdata(rdat));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      give_verdict();
    end
  end
  // Band 3 holds real limits; other slots get an empty band that never hits.
  function automatic logic [15:0] val(int b, int i);
    if (b != 3) return (i == 0) ? 16'h0001 : 16'h0000;
    return (i < 2) ? 16'h0010 << i : 16'(16'h0100 * i);
  endfunction
  task automatic record();
    @(posedge clk);
    #1;
    rec = 1'b1;
    @(posedge clk);
    #1;
    rec = 1'b0;
    repeat (10) @(posedge clk);
    #1;
  endtask
  initial begin
    reset = 1'b1;
    rec = 1'b0;
    clr = 1'b0;
    rate = 2'h2;
    mode = VAC_MODE_OFF;
    meas = '0;
    temp = 16'h0900;
    supp = 16'h0700;
    repeat (12) @(posedge clk);
    #1;
    reset = 1'b0;
    host_u.rd(7'h34, d);
    check(d, 16'h0080);
    host_u.rd(7'h30, d);
    check(d, 16'h0000);
    host_u.rd(7'h3e, d);
    check(d, 16'h0000);
    host_u.wr(7'h32, 16'h0800);
    host_u.rd(7'h32, d);
    check(d, 16'h0800);
    for (int k = 0; k < 4; k++) begin
      host_u.wr(7'h34, 16'(16'h0048 | (k << 4)));
      repeat (4) @(posedge clk);
      #1;
      check({15'h0, p1}, 16'(k == 1 || k == 2));
    end
    for (int b = 0; b < 8; b++) begin
      host_u.wr(7'h30, {8'h02, 8'(b)});
      for (int i = 0; i < 8; i++) begin
        host_u.wr(7'(7'h20 + 2 * i), val(b, i));
      end
    end
    host_u.wr(7'h30, 16'h0203);
    host_u.rd(7'h30, d);
    check(d, 16'h0203);
    for (int i = 0; i < 8; i++) begin
      host_u.rd(7'(7'h20 + 2 * i), d);
      check(d, val(3, i));
    end
    host_u.wr(7'h34, 16'h0042);
    mode = VAC_MODE_SPEC;
    meas.mag_x = 16'h0900;
    meas.mag_y = 16'h0350;
    meas.mag_z = 16'h0100;
    record();
    check({14'h0, p1, p2}, 16'h0002);
    host_u.rd(7'h3c, d);
    check(d, 16'h0200);
    host_u.rd(7'h3c, d);
    check(d, 16'h0000);
    host_u.wr(7'h34, 16'h1047);
    record();
    check({14'h0, p1, p2}, 16'h0003);
    host_u.rd(7'h3c, d);
    check(d, 16'h0b00);
    host_u.rd(7'h3c, d);
    check(d, 16'h0b00);
    // Response delay of two: the flag waits for the third hitting record.
    host_u.wr(7'h34, 16'h0202);
    host_u.rd(7'h3c, d);
    check(d, 16'h0b00);
    for (int n = 0; n < 3; n++) begin
      record();
      host_u.rd(7'h3c, d);
      check(d, (n == 2) ? 16'h0200 : 16'h0000);
    end
    // Time capture compares the selected alarm; z takes root-sum-square when enabled.
    host_u.wr(7'h34, 16'h0004);
    mode = VAC_MODE_TIME;
    meas.root_sum_square = 16'h0800;
    meas.rss_en = 1'b1;
    record();
    host_u.rd(7'h3c, d);
    check(d, 16'h2400);
    host_u.rd(7'h3c, d);
    check(d, 16'h0000);
    meas.rss_en = 1'b0;
    meas.mag_z = 16'h0450;
    record();
    host_u.rd(7'h3c, d);
    check(d, 16'h0400);
    // A latched system flag outlives its cause until the clear-status pulse.
    host_u.wr(7'h34, 16'h00d8);
    repeat (3) @(posedge clk);
    #1;
    temp = 16'h0700;
    host_u.rd(7'h3c, d);
    check(d, 16'h4000);
    check({15'h0, p1}, 16'h0001);
    @(posedge clk);
    #1;
    clr = 1'b1;
    @(posedge clk);
    #1;
    clr = 1'b0;
    host_u.rd(7'h3c, d);
    check(d, 16'h0000);
    give_verdict();
  end
endmodule
bind vac_alarm_config vac_alarm_config_props chk_u (.*);
